// ---- rtl/irm_bit_cell.sv ----
// Purpose: one set/clear mask bit
// Assumes: set and clear never both asserted by the caller's decode
// Notes: holds its value when neither strobe is high
`timescale 1ns/1ps
module irm_bit_cell (
	input wire logic mclk, // clock
	input wire logic set_pulse, // write-one-to-set strobe
	input wire logic clr_pulse, // write-one-to-clear strobe
	output logic q // stored bit
);
	logic next_q;
	always_comb begin
		next_q = q;
		if (set_pulse) begin
			next_q = 1'b1;
		end else if (clr_pulse) begin
			next_q = 1'b0;
		end
	end
	// no reset term: the bit is left undefined by reset on purpose
	always_ff @(posedge mclk) begin
		q <= next_q;
	end
endmodule : irm_bit_cell

// ---- rtl/irm_chan_match.sv ----
// Purpose: compare an incoming channel number against the mask
// Assumes: channel numbers 0..63 on a 6-bit field
// Notes: combinational; lower half always answers no here
`timescale 1ns/1ps
module irm_chan_match (
	input wire logic [irm_pkg::CHAN_W-1:0] chan, // packet channel
	input wire logic [irm_pkg::DATA_W-1:0] mask, // upper mask
	output logic hit // accept this channel
);
	logic [irm_pkg::CHAN_W-2:0] idx;
	always_comb begin
		idx = chan[irm_pkg::CHAN_W-2:0];
		hit = 1'b0;
		if (chan >= irm_pkg::CHAN_BASE) begin
			hit = mask[idx];
		end
	end
endmodule : irm_chan_match

// ---- rtl/irm_mask_high.sv ----
// Purpose: upper isochronous receive channel mask with set and clear aliases
// Assumes: Avalon-MM master holds requests until waitrequest is low
// Notes: every access completes in the cycle after it is seen
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module irm_mask_high (
	input wire logic mclk, // 10 MHz clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [irm_pkg::ADDR_W-1:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [irm_pkg::DATA_W-1:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [irm_pkg::DATA_W-1:0] avs_readdata, // read data
	output logic [1:0] avs_response, // 0 ok, 3 decode error
	output logic avs_waitrequest, // high until the access is answered
	input wire logic [irm_pkg::CHAN_W-1:0] rx_chan, // channel of arriving iso packet
	input wire logic rx_chan_valid, // rx_chan is meaningful
	output logic rx_accept, // packet on rx_chan may be received
	output logic [irm_pkg::DATA_W-1:0] chan_mask // mask to receive path
);
	typedef enum logic {IRM_IDLE, IRM_DONE} irm_state_e;
	irm_state_e state, next_state;
	logic [irm_pkg::DATA_W-1:0] readdata, next_readdata;
	logic [1:0] response, next_response;
	logic [irm_pkg::DATA_W-1:0] lane_mask, set_vec, clr_vec;
	logic hit_set, hit_clr, req, hit;

	always_comb begin
		req = avs_read | avs_write;
		hit_set = (avs_address == irm_pkg::OFS_MASK_SET);
		hit_clr = (avs_address == irm_pkg::OFS_MASK_CLEAR);
		for (int i = 0; i < 4; i++) begin
			lane_mask[8*i +: 8] = {8{avs_byteenable[i]}};
		end
	end

	// strobe in the answer cycle so the update lands at the edge waitrequest is low
	always_comb begin
		set_vec = '0;
		clr_vec = '0;
		if (state == IRM_DONE && avs_write && hit_set) begin
			set_vec = avs_writedata & lane_mask;
		end
		if (state == IRM_DONE && avs_write && hit_clr) begin
			clr_vec = avs_writedata & lane_mask;
		end
	end

	property p_lane_gate;
		@(posedge mclk) disable iff (rst)
		((set_vec | clr_vec) & ~lane_mask) == '0;
	endproperty
	a_lane_gate: assert property (p_lane_gate) else $error("disabled lane hit the mask");

	property p_rd_no_strobe;
		@(posedge mclk) disable iff (rst)
		avs_read |-> ((set_vec | clr_vec) == '0);
	endproperty
	a_rd_no_strobe: assert property (p_rd_no_strobe) else $error("read touched mask");

	property p_set_clr_excl;
		@(posedge mclk) disable iff (rst)
		!((set_vec != '0) && (clr_vec != '0));
	endproperty
	a_set_clr_excl: assert property (p_set_clr_excl) else $error("set and clear together");

	property p_strobe_done;
		@(posedge mclk) disable iff (rst)
		((set_vec | clr_vec) != '0) |-> (state == IRM_DONE);
	endproperty
	a_strobe_done: assert property (p_strobe_done) else $error("strobe outside answer");

	// cells carry no reset: the mask is undefined until software writes it
	for (genvar b = 0; b < irm_pkg::DATA_W; b++) begin : g_bit
		irm_bit_cell u_cell (
			.mclk(mclk),
			.set_pulse(set_vec[b]),
			.clr_pulse(clr_vec[b]),
			.q(chan_mask[b])
		);
	end

	irm_chan_match u_match (
		.chan(rx_chan),
		.mask(chan_mask),
		.hit(hit)
	);
	assign rx_accept = rx_chan_valid & hit;

	// both ends of the range are checked: an index slip would hide in the middle
	property p_top_chan;
		@(posedge mclk) disable iff (rst)
		(rx_chan_valid && rx_chan == {irm_pkg::CHAN_W{1'b1}})
		|-> (rx_accept == chan_mask[irm_pkg::DATA_W-1]);
	endproperty
	a_top_chan: assert property (p_top_chan) else $error("top channel not on top bit");

	property p_base_chan;
		@(posedge mclk) disable iff (rst)
		(rx_chan_valid && rx_chan == irm_pkg::CHAN_BASE) |-> (rx_accept == chan_mask[0]);
	endproperty
	a_base_chan: assert property (p_base_chan) else $error("base channel not on bit 0");

	property p_valid_gate;
		@(posedge mclk) disable iff (rst)
		!rx_chan_valid |-> !rx_accept;
	endproperty
	a_valid_gate: assert property (p_valid_gate) else $error("accept without valid");

	property p_accept_upper;
		@(posedge mclk) disable iff (rst)
		rx_accept |-> (rx_chan_valid && rx_chan >= irm_pkg::CHAN_BASE);
	endproperty
	a_accept_upper: assert property (p_accept_upper) else $error("accept outside upper half");

	always_comb begin
		next_state = state;
		next_readdata = readdata;
		next_response = response;
		case (state)
			IRM_IDLE: begin
				if (req) begin
					next_state = IRM_DONE;
					next_response = (hit_set | hit_clr) ? irm_pkg::RESP_OK : irm_pkg::RESP_DECERR;
					next_readdata = irm_pkg::UNMAPPED_READ;
					if (avs_read && (hit_set | hit_clr)) begin
						next_readdata = chan_mask;
					end
				end
			end
			IRM_DONE: begin
				next_state = IRM_IDLE;
			end
			default: begin
				next_state = IRM_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= IRM_IDLE;
			readdata <= irm_pkg::UNMAPPED_READ;
			response <= irm_pkg::RESP_OK;
		end else begin
			state <= next_state;
			readdata <= next_readdata;
			response <= next_response;
		end
	end

	assign avs_waitrequest = !(state == IRM_DONE);
	assign avs_readdata = readdata;
	assign avs_response = response;

	property p_set_bits;
		@(posedge mclk) disable iff (rst)
		(state == IRM_DONE && avs_write && hit_set) |=> ((chan_mask & $past(set_vec)) == $past(set_vec));
	endproperty
	a_set_bits: assert property (p_set_bits) else $error("set write did not set bits");

	property p_clr_bits;
		@(posedge mclk) disable iff (rst)
		(state == IRM_DONE && avs_write && hit_clr) |=> ((chan_mask & $past(clr_vec)) == '0);
	endproperty
	a_clr_bits: assert property (p_clr_bits) else $error("clear write did not clear bits");

	property p_zero_keep;
		@(posedge mclk) disable iff (rst)
		(state == IRM_DONE && avs_write && (hit_set | hit_clr))
		|=> ((chan_mask & ~$past(set_vec | clr_vec)) == ($past(chan_mask) & ~$past(set_vec | clr_vec)));
	endproperty
	a_zero_keep: assert property (p_zero_keep) else $error("zero bits changed the mask");

	property p_read_value;
		@(posedge mclk) disable iff (rst)
		(state == IRM_IDLE && avs_read && (hit_set | hit_clr)) |=> (avs_readdata == $past(chan_mask));
	endproperty
	a_read_value: assert property (p_read_value) else $error("read did not return mask");

	property p_read_stable;
		@(posedge mclk) disable iff (rst)
		(state == IRM_IDLE && avs_read) |=> $stable(chan_mask);
	endproperty
	a_read_stable: assert property (p_read_stable) else $error("read changed the mask");

	property p_accept;
		@(posedge mclk) disable iff (rst)
		rx_chan_valid && rx_chan >= irm_pkg::CHAN_BASE
		|-> (rx_accept == chan_mask[rx_chan[irm_pkg::CHAN_W-2:0]]);
	endproperty
	a_accept: assert property (p_accept) else $error("accept disagrees with mask bit");

	property p_lower_reject;
		@(posedge mclk) disable iff (rst)
		(rx_chan < irm_pkg::CHAN_BASE) |-> !rx_accept;
	endproperty
	a_lower_reject: assert property (p_lower_reject) else $error("lower channel accepted");

	property p_answer_time;
		@(posedge mclk) disable iff (rst)
		(state == IRM_IDLE && req) |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_answer_time: assert property (p_answer_time) else $error("answer not one cycle later");

	property p_unmapped;
		@(posedge mclk) disable iff (rst)
		(state == IRM_IDLE && req && !(hit_set | hit_clr)) |=> (avs_response == irm_pkg::RESP_DECERR);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

	property p_no_spont;
		@(posedge mclk) disable iff (rst)
		!(state == IRM_DONE && avs_write) |=> (chan_mask === $past(chan_mask));
	endproperty
	a_no_spont: assert property (p_no_spont) else $error("mask changed without write");

	// the bus side below pins down the one-cycle answer that software relies on
	property p_rst_wait;
		@(posedge mclk)
		rst |=> (avs_waitrequest && avs_readdata == irm_pkg::UNMAPPED_READ
			&& avs_response == irm_pkg::RESP_OK);
	endproperty
	a_rst_wait: assert property (p_rst_wait) else $error("bus outputs not idle after reset");

	property p_wait_idle;
		@(posedge mclk) disable iff (rst)
		(state == IRM_IDLE) |-> avs_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low while idle");

	property p_wait_done;
		@(posedge mclk) disable iff (rst)
		(state == IRM_DONE) |-> !avs_waitrequest;
	endproperty
	a_wait_done: assert property (p_wait_done) else $error("waitrequest high in answer cycle");

	property p_done_once;
		@(posedge mclk) disable iff (rst)
		(state == IRM_DONE) |=> (state == IRM_IDLE);
	endproperty
	a_done_once: assert property (p_done_once) else $error("answer lasted more than one cycle");

	property p_resp_ok;
		@(posedge mclk) disable iff (rst)
		(state == IRM_IDLE && req && (hit_set | hit_clr)) |=> (avs_response == irm_pkg::RESP_OK);
	endproperty
	a_resp_ok: assert property (p_resp_ok) else $error("mapped access not answered ok");

	property p_unmapped_zero;
		@(posedge mclk) disable iff (rst)
		(state == IRM_IDLE && avs_read && !(hit_set | hit_clr))
		|=> (avs_readdata == irm_pkg::UNMAPPED_READ);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	property p_write_rdata;
		@(posedge mclk) disable iff (rst)
		(state == IRM_IDLE && avs_write) |=> (avs_readdata == irm_pkg::UNMAPPED_READ);
	endproperty
	a_write_rdata: assert property (p_write_rdata) else $error("write left read data set");

	property p_unmapped_keep;
		@(posedge mclk) disable iff (rst)
		(state == IRM_DONE && avs_write && !(hit_set | hit_clr))
		|=> (chan_mask === $past(chan_mask));
	endproperty
	a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write hit mask");

	property p_rdata_hold;
		@(posedge mclk) disable iff (rst)
		!(state == IRM_IDLE && req) |=> $stable(avs_readdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between accesses");

	property p_resp_hold;
		@(posedge mclk) disable iff (rst)
		!(state == IRM_IDLE && req) |=> $stable(avs_response);
	endproperty
	a_resp_hold: assert property (p_resp_hold) else $error("response moved between accesses");

	property p_clr_no_rise;
		@(posedge mclk) disable iff (rst)
		(state == IRM_DONE && avs_write && hit_clr) |=> ((chan_mask & ~$past(chan_mask)) == '0);
	endproperty
	a_clr_no_rise: assert property (p_clr_no_rise) else $error("clear write set a bit");

	property p_set_no_fall;
		@(posedge mclk) disable iff (rst)
		(state == IRM_DONE && avs_write && hit_set) |=> (($past(chan_mask) & ~chan_mask) == '0);
	endproperty
	a_set_no_fall: assert property (p_set_no_fall) else $error("set write cleared a bit");

	c_set: cover property (@(posedge mclk) disable iff (rst) state == IRM_IDLE && avs_write && hit_set);
	c_clr: cover property (@(posedge mclk) disable iff (rst) state == IRM_IDLE && avs_write && hit_clr);
	c_read: cover property (@(posedge mclk) disable iff (rst) state == IRM_IDLE && avs_read && hit_clr);
	c_accept: cover property (@(posedge mclk) disable iff (rst) rx_accept);
	c_decerr: cover property (@(posedge mclk) disable iff (rst) avs_response == irm_pkg::RESP_DECERR);
endmodule : irm_mask_high

// ---- rtl/irm_pkg.sv ----
// Purpose: constants for the upper isochronous receive channel mask block
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes: register word offsets are byte addresses
package irm_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned CHAN_W = 6;
	localparam logic [ADDR_W-1:0] OFS_MASK_SET = 8'h70;
	localparam logic [ADDR_W-1:0] OFS_MASK_CLEAR = 8'h74;
	localparam logic [CHAN_W-1:0] CHAN_BASE = 6'h20;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;
	// nominal value only; the mask cells power up unknown and reset leaves them alone
	localparam logic [DATA_W-1:0] MASK_POWERUP = 32'h00000000;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : irm_pkg

// ---- tb/irm_mask_high_test.sv ----
// Purpose: self-checking bench for the upper channel mask block
// Assumes: one bus access at a time, one idle cycle between accesses
// Notes: waitrequest and read data are taken at the rising edge, before it updates them
`timescale 1ns/1ps
module irm_mask_high_test;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic [1:0] avs_response;
	logic avs_waitrequest;
	logic [5:0] rx_chan = 6'h00;
	logic rx_chan_valid = 1'b0;
	logic rx_accept;
	logic [31:0] chan_mask;
	logic [31:0] q;
	logic [1:0] r;
	logic [31:0] exp_m;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;

	always #50 mclk = ~mclk;

	irm_mask_high irm_mask_high_i (.mclk(mclk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
		.rx_chan(rx_chan), .rx_chan_valid(rx_chan_valid), .rx_accept(rx_accept),
		.chan_mask(chan_mask));

	task automatic report_and_stop;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// entered just after a rising edge; leaves just after one, bus idle
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		r = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : acc

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		// mask has no reset value, so program every bit first
		acc(1'b1, irm_pkg::OFS_MASK_CLEAR, 32'hFFFFFFFF, 4'hF);
		acc(1'b0, irm_pkg::OFS_MASK_SET, 32'h00000000, 4'hF);
		chk(q, 32'h00000000);
		acc(1'b1, irm_pkg::OFS_MASK_SET, 32'hFFFFFFFF, 4'hF);
		chk({30'h0, r}, 32'h00000000);
		acc(1'b0, irm_pkg::OFS_MASK_CLEAR, 32'h00000000, 4'hF);
		chk(q, 32'hFFFFFFFF);
		acc(1'b1, irm_pkg::OFS_MASK_CLEAR, 32'h0F0F00FF, 4'hF);
		chk(chan_mask, 32'hF0F0FF00);
		acc(1'b1, irm_pkg::OFS_MASK_SET, 32'h00000005, 4'hF);
		acc(1'b0, irm_pkg::OFS_MASK_SET, 32'h00000000, 4'hF);
		chk(q, 32'hF0F0FF05);
		acc(1'b0, irm_pkg::OFS_MASK_CLEAR, 32'hFFFFFFFF, 4'hF);
		chk(q, 32'hF0F0FF05);
		exp_m = 32'hF0F0FF05;
		// last pass drops valid on channel 63, which the mask enables
		for (int i = 0; i < 65; i++) begin
			rx_chan <= (i < 64) ? i[5:0] : 6'h3F;
			rx_chan_valid <= (i < 64);
			@(negedge mclk);
			chk({31'h0, rx_accept}, {31'h0, (i >= 32 && i < 64) ? exp_m[i[4:0]] : 1'b0});
			@(posedge mclk);
		end
		acc(1'b0, 8'h78, 32'h00000000, 4'hF);
		chk(q, irm_pkg::UNMAPPED_READ);
		chk({30'h0, r}, {30'h0, irm_pkg::RESP_DECERR});
		acc(1'b1, 8'h7C, 32'hFFFFFFFF, 4'hF);
		chk(chan_mask, 32'hF0F0FF05);
		// disabled byte lanes behave as zero bits
		acc(1'b1, irm_pkg::OFS_MASK_CLEAR, 32'hFFFFFFFF, 4'h1);
		chk(chan_mask, 32'hF0F0FF00);
		acc(1'b1, irm_pkg::OFS_MASK_SET, 32'hFFFFFFFF, 4'h8);
		chk(chan_mask, 32'hFFF0FF00);
		report_and_stop();
	end
endmodule : irm_mask_high_test
